// ==== hdl/hmb_pkg.sv ====
/*
  Shared constants for the link message buffer/count block.
  Assumes a 32-bit APB slave with word-aligned register slots.
*/
package hmb_pkg;
  // Address bus width in bits
  localparam int ADDR_W = 12;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h153;
  localparam logic [9:0] IDX_TXC  = 10'h154;
  localparam logic [9:0] IDX_RXC  = 10'h155;
  localparam logic [9:0] IDX_STAT = 10'h156;
  localparam logic [9:0] IDX_MASK = 10'h157;
  // Count field width and buffer select/pointer bit
  localparam int CNT_W   = 7;
  localparam int SEL_BIT = 7;
  // Control bits
  localparam int CTRL_MSG   = 0;
  localparam int CTRL_FCS   = 1;
  localparam int CTRL_RXMOS = 2;
  localparam int CTRL_W     = 3;
  // Status and mask bits
  localparam int ST_TX_END_OF_TRANSFER = 0;
  localparam int ST_RX_END_OF_TRANSFER = 1;
  localparam int ST_RXMSG = 2;
  localparam int ST_W     = 3;
  // Reset values
  localparam logic [7:0]        RST_TXC  = 8'h00;
  localparam logic [7:0]        RST_RXC  = 8'h00;
  localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;
  localparam logic [ST_W-1:0]   RST_MASK = 3'h0;
  // Message buffer base offsets inside a channel
  localparam logic [11:0] TXBUF0_BASE = 12'h600;
  localparam logic [11:0] TXBUF1_BASE = 12'h700;
  // Transmit sequencer states, one-hot
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_FCS  = 3'b100
  } hmb_tx_state_t;
endpackage : hmb_pkg

// ==== hdl/hmb_tx_seq.sv ====
/*
  Transmit sequencer: counts octets or repetitions of one buffer.
  Assumes the link engine pulses one strobe per octet/repetition.
*/
`timescale 1ns/10ps
`default_nettype none
module hmb_tx_seq import hmb_pkg::*; (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Start request, sampled together
  input  wire logic             start,
  input  wire logic             sel,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             msg,
  input  wire logic             fcs_en,
  // Link engine strobes
  input  wire logic             octet_taken,
  input  wire logic             fcs_done,
  input  wire logic             rep_done,
  // Status
  output logic                  active_q,
  output logic                  buf_q,
  output logic                  msg_q,
  output logic [CNT_W-1:0]      idx_q,
  output logic                  fcs_phase_q,
  output logic                  done_q
);
  hmb_tx_state_t    state_q;  // Sequencer state
  logic [CNT_W-1:0] cnt_q;    // Programmed count
  logic             fcs_q;    // Checksum append enabled
  logic [CNT_W-1:0] nxt;      // Next index
  assign nxt = CNT_W'(idx_q + 1'b1);

  // Sequencer; a zero repeat count never finishes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= TX_IDLE;
      active_q    <= 1'b0;
      buf_q       <= 1'b0;
      msg_q       <= 1'b0;
      fcs_q       <= 1'b0;
      cnt_q       <= '0;
      idx_q       <= '0;
      fcs_phase_q <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        TX_IDLE: begin
          if (start) begin
            state_q  <= TX_SEND;
            active_q <= 1'b1;
            buf_q    <= sel;
            msg_q    <= msg;
            fcs_q    <= fcs_en & msg;
            cnt_q    <= count;
            idx_q    <= '0;
          end
        end
        TX_SEND: begin
          if (msg_q && (cnt_q == '0 || (octet_taken && nxt == cnt_q))) begin
            if (fcs_q) begin
              state_q     <= TX_FCS;
              fcs_phase_q <= 1'b1;
            end else begin
              state_q  <= TX_IDLE;
              active_q <= 1'b0;
              done_q   <= 1'b1;
            end
          end else if (msg_q && octet_taken) begin
            idx_q <= nxt;
          end else if (!msg_q && rep_done) begin
            if (cnt_q != '0 && nxt == cnt_q) begin
              state_q  <= TX_IDLE;
              active_q <= 1'b0;
              done_q   <= 1'b1;
            end else begin
              idx_q <= (cnt_q == '0) ? '0 : nxt;
            end
          end
        end
        TX_FCS: begin
          if (fcs_done) begin
            state_q     <= TX_IDLE;
            active_q    <= 1'b0;
            fcs_phase_q <= 1'b0;
            done_q      <= 1'b1;
          end
        end
        default: begin
          state_q  <= TX_IDLE;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // Repeat-forever mode never ends
  rep_forever_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (active_q && !msg_q && cnt_q == '0) |=> !done_q)
    else $error("zero repeat count ended");

  // Repetition end falls on the programmed count
  rep_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == TX_SEND && !msg_q && rep_done && cnt_q != '0
     && nxt == cnt_q) |=> (done_q && !active_q))
    else $error("repeat end missed");
endmodule : hmb_tx_seq
`default_nettype wire

// ==== hdl/hmb_rx_seq.sv ====
/*
  Receive repetition counter for bit-oriented reception.
  Assumes one rep_done pulse per received repetition.
*/
`timescale 1ns/10ps
`default_nettype none
module hmb_rx_seq import hmb_pkg::*; (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Configuration
  input  wire logic             rep_mode,
  input  wire logic [CNT_W-1:0] target,
  input  wire logic             restart,
  // Link strobe
  input  wire logic             rep_done,
  // Event
  output logic [CNT_W-1:0]      reps_q,
  output logic                  eot_q
);
  logic [CNT_W-1:0] nxt;  // Next count
  assign nxt = CNT_W'(reps_q + 1'b1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reps_q <= '0;
      eot_q  <= 1'b0;
    end else begin
      eot_q <= 1'b0;
      if (restart) begin
        reps_q <= '0;
      end else if (rep_mode && rep_done && target != '0) begin
        if (nxt == target) begin
          reps_q <= '0;
          eot_q  <= 1'b1;
        end else begin
          reps_q <= nxt;
        end
      end
    end
  end

  // Zero target raises no end event
  rx_forever_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (target == '0 && $past(target) == '0) |-> !eot_q)
    else $error("rx end with zero target");

  // End event follows the final repetition
  rx_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rep_mode && rep_done && !restart && target != '0 && nxt == target)
    |=> eot_q)
    else $error("rx end missed");
endmodule : hmb_rx_seq
`default_nettype wire

// ==== hdl/hmb_top.sv ====
/*
  Message buffer selection and byte/repetition counting for the
  third data-link controller pair, with APB registers and IRQ.
  Assumes a link engine that moves octets and reports strobes,
  and an APB master obeying the usual setup/access protocol.
*/
// Decided for this implementation: the APB interface to the registers.
// Contract
// - Select bit chooses transmit buffer
// - Read bit shows next free buffer
// - Busy buffer forces other buffer shown (with both busy, the code shows the buffer not last written)
// - Bit mode: repeat count then interrupt
// - Bit mode zero count repeats forever
// - Message mode sends exact octet count
// - Checksum octets added beyond count
// - Receive pointer names newest buffer
// - Receive repeat count raises end
// - Receive zero count never ends
// - Receive size includes header and checksum
`timescale 1ns/10ps
`default_nettype none
module hmb_top import hmb_pkg::*; (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Transmit link engine
  input  wire logic              tx_octet_taken,
  input  wire logic              tx_fcs_done,
  input  wire logic              tx_rep_done,
  output logic                   tx_active,
  output logic                   tx_buffer,
  output logic                   tx_msg_mode,
  output logic [CNT_W-1:0]       tx_octet_index,
  output logic                   tx_fcs_phase,
  // Receive link engine
  input  wire logic              rx_rep_done,
  input  wire logic              rx_msg_done,
  input  wire logic              rx_msg_buffer,
  input  wire logic [CNT_W-1:0]  rx_msg_length,
  // Interrupt
  output logic                   irq
);

  // Decode helper: word-aligned hit on a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0]        idx);
    hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  // Bus phase terms
  logic pready_q;     // Answer flag
  logic [31:0] prd_q; // Read data
  logic perr_q;       // Unmapped access
  logic acc_s;        // First access cycle
  logic fin_s;        // Completing edge
  logic wr_s;         // Write takes effect

  // Register state
  logic [CTRL_W-1:0] ctrl_q;  // Mode and checksum control
  logic [CNT_W-1:0]  txcnt_q; // Last written transmit count
  logic              rxptr_q; // Newest receive buffer
  logic [CNT_W-1:0]  rxcnt_q; // Receive count field
  logic [ST_W-1:0]   stat_q;  // Sticky events
  logic [ST_W-1:0]   mask_q;  // Interrupt enables
  logic              irq_q;   // Registered interrupt

  // Transmit buffer bookkeeping
  logic [1:0]       pend_q;  // Buffer holds unsent message
  logic             last_q;  // Most recently chosen buffer
  logic             qv_q;    // Queued start waiting
  logic             qbuf_q;  // Queued buffer
  logic [CNT_W-1:0] qcnt_q;  // Queued count
  logic             avail;   // Next free buffer
  logic             start;   // Sequencer start
  logic             s_sel;   // Start buffer
  logic [CNT_W-1:0] s_cnt;   // Start count
  logic             wr_txc;  // Count register write
  logic             wr_rxc;  // Receive register write

  // Sequencer results
  logic             seq_act;
  logic             seq_buf;
  logic             seq_msg;
  logic [CNT_W-1:0] seq_idx;
  logic             seq_fcs;
  logic             seq_done;
  logic             rx_eot;
  logic [ST_W-1:0]  ev_set;

  assign acc_s  = psel & penable & ~pready_q;
  assign fin_s  = psel & penable & pready_q;
  assign wr_s   = fin_s & pwrite;
  assign wr_txc = wr_s & hit(paddr, IDX_TXC);
  assign wr_rxc = wr_s & hit(paddr, IDX_RXC);

  // One wait state: answer in the cycle after access begins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
    end else begin
      pready_q <= acc_s;
      perr_q   <= acc_s & ~(hit(paddr, IDX_CTRL) | hit(paddr, IDX_TXC)
                  | hit(paddr, IDX_RXC) | hit(paddr, IDX_STAT)
                  | hit(paddr, IDX_MASK));
    end
  end

  // free buffer for the host
  // Neither or both busy: ping-pong against the last choice
  always_comb begin
    if (pend_q[0] ^ pend_q[1]) begin
      avail = pend_q[0];
    end else begin
      avail = ~last_q;
    end
  end

  // Read mux, registered with the answer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prd_q <= 32'h0000_0000;
    end else if (acc_s && !pwrite) begin
      prd_q <= 32'h0000_0000;
      if (hit(paddr, IDX_CTRL)) begin
        prd_q[CTRL_W-1:0] <= ctrl_q;
      end else if (hit(paddr, IDX_TXC)) begin
        prd_q[7:0] <= {avail, txcnt_q};
      end else if (hit(paddr, IDX_RXC)) begin
        prd_q[7:0] <= {rxptr_q, rxcnt_q};
      end else if (hit(paddr, IDX_STAT)) begin
        prd_q[ST_W-1:0] <= stat_q;
      end else if (hit(paddr, IDX_MASK)) begin
        prd_q[ST_W-1:0] <= mask_q;
      end
    end
  end

  // Plain control and mask registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= RST_CTRL;
      mask_q <= RST_MASK;
    end else begin
      if (wr_s && hit(paddr, IDX_CTRL)) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
      if (wr_s && hit(paddr, IDX_MASK)) begin
        mask_q <= pwdata[ST_W-1:0];
      end
    end
  end

  // write launches or queues
  // A write while busy waits in a one-deep queue;
  // a second write while queued replaces the first.
  always_comb begin
    start = 1'b0;
    s_sel = pwdata[SEL_BIT];
    s_cnt = pwdata[CNT_W-1:0];
    if (!seq_act && qv_q) begin
      start = 1'b1;
      s_sel = qbuf_q;
      s_cnt = qcnt_q;
    end else if (!seq_act && wr_txc) begin
      start = 1'b1;
    end
  end

  // Transmit count register, queue and buffer occupancy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txcnt_q <= RST_TXC[CNT_W-1:0];
      last_q  <= 1'b1;
      pend_q  <= 2'b00;
      qv_q    <= 1'b0;
      qbuf_q  <= 1'b0;
      qcnt_q  <= '0;
    end else begin
      if (start && qv_q) begin
        qv_q <= 1'b0;
      end
      if (wr_txc) begin
        txcnt_q <= pwdata[CNT_W-1:0];
        last_q  <= pwdata[SEL_BIT];
        if (seq_act || qv_q) begin
          qv_q   <= 1'b1;
          qbuf_q <= pwdata[SEL_BIT];
          qcnt_q <= pwdata[CNT_W-1:0];
        end
      end
      // Set wins over the finishing clear
      for (int b = 0; b < 2; b++) begin
        if (wr_txc && pwdata[SEL_BIT] == b[0]) begin
          pend_q[b] <= 1'b1;
        end else if (seq_done && seq_buf == b[0]) begin
          pend_q[b] <= 1'b0;
        end
      end
    end
  end

  // Transmit sequencer
  hmb_tx_seq u_tx (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .start       (start),
    .sel         (s_sel),
    .count       (s_cnt),
    .msg         (ctrl_q[CTRL_MSG]),
    .fcs_en      (ctrl_q[CTRL_FCS]),
    .octet_taken (tx_octet_taken),
    .fcs_done    (tx_fcs_done),
    .rep_done    (tx_rep_done),
    .active_q    (seq_act),
    .buf_q       (seq_buf),
    .msg_q       (seq_msg),
    .idx_q       (seq_idx),
    .fcs_phase_q (seq_fcs),
    .done_q      (seq_done)
  );

  // Receive repetition counter
  hmb_rx_seq u_rx (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .rep_mode (~ctrl_q[CTRL_RXMOS]),
    .target   (rxcnt_q),
    .restart  (wr_rxc),
    .rep_done (rx_rep_done),
    .reps_q   (),
    .eot_q    (rx_eot)
  );

  // Receive pointer and count; hardware update wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxptr_q <= RST_RXC[SEL_BIT];
      rxcnt_q <= RST_RXC[CNT_W-1:0];
    end else begin
      if (wr_rxc) begin
        rxptr_q <= pwdata[SEL_BIT];
        rxcnt_q <= pwdata[CNT_W-1:0];
      end
      if (rx_msg_done) begin
        rxptr_q <= rx_msg_buffer;
      end
      if (rx_msg_done && ctrl_q[CTRL_RXMOS]) begin
        rxcnt_q <= rx_msg_length;
      end
    end
  end

  // Event sources for the sticky status
  always_comb begin
    ev_set           = '0;
    ev_set[ST_TX_END_OF_TRANSFER] = seq_done;
    ev_set[ST_RX_END_OF_TRANSFER] = rx_eot;
    ev_set[ST_RXMSG] = rx_msg_done;
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else if (wr_s && hit(paddr, IDX_STAT)) begin
      stat_q <= (stat_q & ~pwdata[ST_W-1:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  // Level interrupt from unmasked status, registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (wr_s && hit(paddr, IDX_STAT)) begin
      irq_q <= |(((stat_q & ~pwdata[ST_W-1:0]) | ev_set) & mask_q);
    end else begin
      irq_q <= |((stat_q | ev_set) & mask_q);
    end
  end

  // Outputs, each straight from a flip-flop
  assign prdata         = prd_q;
  assign pready         = pready_q;
  assign pslverr        = perr_q;
  assign tx_active      = seq_act;
  assign tx_buffer      = seq_buf;
  assign tx_octet_index = seq_idx;
  assign tx_fcs_phase   = seq_fcs;
  assign irq            = irq_q;

  // Mode flag captured at start; reset shows bit mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_msg_mode <= 1'b0;
    end else begin
      tx_msg_mode <= (start) ? ctrl_q[CTRL_MSG] : tx_msg_mode;
    end
  end

  // Answer sequence of one transfer
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_answer_s;
    penable && !pready ##1 pready;
  endsequence

  // Slave answers one cycle after access begins
  apb_answer_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    apb_setup_s ##1 (psel && penable) |-> apb_answer_s)
    else $error("apb answer late");

  // Started buffer is the written select
  tx_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_txc && !seq_act && !qv_q) |=>
    (seq_act && seq_buf == $past(pwdata[SEL_BIT])))
    else $error("wrong buffer started");

  // A lone busy buffer is never reported free
  tx_avail_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pend_q == 2'b01 || pend_q == 2'b10) |->
    avail == ~pend_q[1])
    else $error("busy buffer shown free");

  // Read data carries the free buffer
  tx_readsel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (acc_s && !pwrite && hit(paddr, IDX_TXC)) |=>
    prdata[SEL_BIT] == $past(avail))
    else $error("select read mismatch");

  // Receive pointer follows a finished message
  rx_ptr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rx_msg_done |=> rxptr_q == $past(rx_msg_buffer))
    else $error("rx pointer not updated");

  // Received size is reported whole
  rx_size_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rx_msg_done && ctrl_q[CTRL_RXMOS]) |=>
    rxcnt_q == $past(rx_msg_length))
    else $error("rx size not reported");

  // Transfer end raises the sticky flag
  tx_eot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_done |=> stat_q[ST_TX_END_OF_TRANSFER])
    else $error("tx end flag lost");

  // Checksum phase only after the counted octets
  tx_fcs_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(seq_fcs) |-> seq_msg && $past(tx_octet_taken)
    || $past(txcnt_q) == '0)
    else $error("checksum phase early");

endmodule : hmb_top
`default_nettype wire

// ==== verification/hmb_link_model.sv ====
/*
  Behavioural model of the transmit link engine that drains a buffer.
  Assumes the sequencer status outputs of hmb_top and a stall input
  from the bench that makes the engine answer slowly at random.
*/
`timescale 1ns/10ps
`default_nettype none
module hmb_link_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Sequencer status
  input  wire logic tx_active,
  input  wire logic tx_msg_mode,
  input  wire logic tx_fcs_phase,
  input  wire logic stall,
  // Engine strobes
  output logic      tx_octet_taken,
  output logic      tx_fcs_done,
  output logic      tx_rep_done
);
  logic beat_q; // Strobe slot; never two cycles in a row

  // Alternate slots so no strobe trails the final accepted one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      beat_q <= 1'b0;
    end else begin
      beat_q <= tx_active && !beat_q && !stall;
    end
  end

  assign tx_octet_taken = beat_q && tx_msg_mode && !tx_fcs_phase;
  assign tx_fcs_done    = beat_q && tx_fcs_phase;
  assign tx_rep_done    = beat_q && !tx_msg_mode;
endmodule : hmb_link_model
`default_nettype wire

// ==== verification/hmb_top_bench.sv ====
/*
  Self-checking bench for hmb_top: APB master, receive strobes, checks.
  Assumes hmb_link_model stands for the transmit engine.
*/
`timescale 1ns/10ps
`default_nettype none
module hmb_top_bench import hmb_pkg::*;;
  logic              sys_clk = 1'b0;     // 100 MHz clock
  logic              nrst, psel, penable, pwrite, stall;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, irq;
  logic              tx_octet_taken, tx_fcs_done, tx_rep_done, tx_active;
  logic              tx_buffer, tx_msg_mode, tx_fcs_phase;
  logic [CNT_W-1:0]  tx_octet_index, rx_msg_length;
  logic              rx_rep_done, rx_msg_done, rx_msg_buffer;
  logic [31:0]       rnd = 32'h12d3;     // Random state
  logic              exp_free = 1'b0;    // Expected free buffer
  logic              saw_fcs;
  int                num_errors = 0, cmp_count = 0, n_oct, n_rep, k;
  logic [31:0]       r;

  always #5 sys_clk = ~sys_clk;

  hmb_top uut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_octet_taken(tx_octet_taken), .tx_fcs_done(tx_fcs_done),
    .tx_rep_done(tx_rep_done), .tx_active(tx_active),
    .tx_buffer(tx_buffer), .tx_msg_mode(tx_msg_mode),
    .tx_octet_index(tx_octet_index), .tx_fcs_phase(tx_fcs_phase),
    .rx_rep_done(rx_rep_done), .rx_msg_done(rx_msg_done),
    .rx_msg_buffer(rx_msg_buffer), .rx_msg_length(rx_msg_length),
    .irq(irq));

  hmb_link_model peer (.sys_clk(sys_clk), .nrst(nrst),
    .tx_active(tx_active), .tx_msg_mode(tx_msg_mode),
    .tx_fcs_phase(tx_fcs_phase), .stall(stall),
    .tx_octet_taken(tx_octet_taken), .tx_fcs_done(tx_fcs_done),
    .tx_rep_done(tx_rep_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Random state and engine stalls advance every cycle
  always @(posedge sys_clk) begin
    rnd   <= lfsr(rnd);
    stall <= rnd[3];
  end

  // Count strobes the sequencer accepts while busy
  always @(posedge sys_clk) begin
    if (tx_active && tx_octet_taken) n_oct++;
    if (tx_active && tx_rep_done) n_rep++;
    if (tx_fcs_phase) saw_fcs = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] d, output logic [31:0] rd_q,
                     output logic err);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, idx, d, x, e);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [31:0] x);
    logic e;
    apb(1'b0, idx, 32'h0, x, e);
  endtask : rd

  // Receive strobe: a finished message or one repetition
  task automatic pulse(input logic msg);
    @(posedge sys_clk);
    rx_msg_done <= msg; rx_rep_done <= !msg;
    @(posedge sys_clk);
    rx_msg_done <= 1'b0; rx_rep_done <= 1'b0;
  endtask : pulse

  // Kind 0 bit mode, 1 message with checksum, 2 message plain
  task automatic tx_run(input int kind, input logic [6:0] cnt,
                        input logic m);
    logic [31:0] x;
    logic        s;
    wr(IDX_STAT, 32'h7);
    wr(IDX_MASK, {31'h0, m});
    wr(IDX_CTRL, {30'h0, kind == 1, kind != 0});
    rd(IDX_TXC, x);
    chk({31'h0, x[7]}, {31'h0, exp_free});
    s = x[7];
    n_oct = 0; n_rep = 0; saw_fcs = 1'b0;
    wr(IDX_TXC, {24'h0, s, cnt});
    exp_free = !s;
    repeat (2) @(negedge sys_clk);
    chk({31'h0, tx_active}, 32'h1);
    chk({31'h0, tx_buffer}, {31'h0, s});
    rd(IDX_TXC, x);
    chk({31'h0, x[7]}, {31'h0, !s});
    if (cnt == 7'h00) return;
    while (tx_active !== 1'b0) @(negedge sys_clk);
    chk(kind != 0 ? n_oct : n_rep, {25'h0, cnt});
    chk({31'h0, saw_fcs}, {31'h0, kind == 1});
    rd(IDX_STAT, x);
    chk({31'h0, x[ST_TX_END_OF_TRANSFER]}, 32'h1);
    chk({31'h0, irq}, {31'h0, m});
    wr(IDX_STAT, 32'h7);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask : tx_run

  // Hang guard, well past the expected run length
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; stall = 1'b0; rx_rep_done = 1'b0;
    rx_msg_done = 1'b0; rx_msg_buffer = 1'b0; rx_msg_length = '0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(IDX_TXC, r);
    chk(r, {24'h0, RST_TXC});
    rd(IDX_RXC, r);
    chk(r, {24'h0, RST_RXC});
    apb(1'b0, 10'h000, 32'h0, r, saw_fcs);
    chk({31'h0, saw_fcs}, 32'h1);
    $display("end of test reset and map");
    // Longest count first, then random counts in every mode
    tx_run(2, 7'h7f, 1'b1);
    for (k = 0; k < 6; k++) begin
      tx_run(k % 3, 7'd2 + {4'h0, rnd[2:0]}, k[0]);
    end
    $display("end of test transmit counts");
    tx_run(0, 7'h00, 1'b1);
    repeat (150) @(negedge sys_clk);
    chk({31'h0, tx_active}, 32'h1);
    chk({25'h0, tx_octet_index}, 32'h0);
    rd(IDX_STAT, r);
    chk({31'h0, r[ST_TX_END_OF_TRANSFER]}, 32'h0);
    @(posedge sys_clk) nrst <= 1'b0;
    repeat (2) @(posedge sys_clk) nrst <= 1'b1;
    $display("end of test endless repeat");
    for (k = 0; k < 2; k++) begin
      wr(IDX_RXC, k == 0 ? 32'h3 : 32'h0);
      wr(IDX_STAT, 32'h7);
      repeat (k == 0 ? 2 : 5) pulse(1'b0);
      rd(IDX_STAT, r);
      chk({31'h0, r[ST_RX_END_OF_TRANSFER]}, 32'h0);
    end
    wr(IDX_RXC, 32'h3);
    repeat (3) pulse(1'b0);
    rd(IDX_STAT, r);
    chk({31'h0, r[ST_RX_END_OF_TRANSFER]}, 32'h1);
    $display("end of test receive repetitions");
    wr(IDX_CTRL, 32'h4);
    for (k = 0; k < 4; k++) begin
      rx_msg_buffer <= rnd[7];
      rx_msg_length <= rnd[6:0];
      pulse(1'b1);
      rd(IDX_RXC, r);
      chk(r, {24'h0, rx_msg_buffer, rx_msg_length});
    end
    $display("end of test receive messages");
    finish_test();
  end
endmodule : hmb_top_bench
`default_nettype wire
